// File: rtl/ofd_decoder.sv
// Operand field decoder for 16-bit core instruction words
`timescale 1ns/1ps
`include "ofd_consts.svh"
module ofd_decoder
   import ofd_pkg::*;
#(
   parameter int PTR_W = 21,                // Table pointer width
   parameter int BANK_W = 4                 // Bank select width
)(
   input  wire logic              clk,        // Core clock
   input  wire logic              reset,      // Sync reset, active high
   input  wire logic [15:0]       instr,      // Instruction word
   input  wire logic              instr_valid,// Word present this cycle
   input  wire ofd_fmt_t          fmt,        // Operand format
   input  wire logic              is_two_word,// First word of pair
   input  wire logic              flow_change,// Skip true or PC loaded
   input  wire logic              bank_wr,    // Load bank register
   input  wire logic [BANK_W-1:0] bank_val,   // Bank register value
   input  wire logic [7:0]        acc_wr_val, // Accumulator data in
   input  wire logic              acc_wr,     // Accumulator write
   input  wire logic [7:0]        result,     // ALU result byte
   input  wire logic              result_wr,  // Result ready to place
   input  wire logic [4:0]        flags_in,   // Five flags from ALU
   input  wire logic [4:0]        flags_we,   // Per-flag update enable
   input  wire logic [15:0]       product,    // Multiply result
   input  wire logic              product_wr, // Product ready
   input  wire logic              pc_high_latch_wr,  // Load high latch
   input  wire logic              pc_upper_latch_wr, // Load upper latch
   input  wire logic [7:0]        latch_val,  // Latch data in
   input  wire logic              pc_load,    // Computed PC load
   input  wire logic [7:0]        pc_low,     // New PC low byte
   input  wire logic              call_ret,   // Call or return now
   input  wire logic              is_return,  // Return, not call
   input  wire logic [7:0]        status_in,  // Live status byte
   input  wire logic              tbl_access, // Table read or write
   input  wire logic              tbl_load,   // Load table pointer
   input  wire logic [PTR_W-1:0]  tbl_load_val, // Pointer load value
   input  wire logic              tbl_lat_wr, // Write table latch
   input  wire logic [7:0]        tbl_lat_val,// Table latch data in
   output logic [11:0]            data_addr,  // Full data address
   output logic                   dest_is_file, // Result to file
   output logic [7:0]             file_wdata, // Data to file
   output logic                   file_we,    // File write strobe
   output logic [7:0]             bit_mask,   // Selected bit mask
   output logic [2:0]             bit_index,  // Selected bit number
   output logic [1:0]             ptr_sel,    // Pointer designator
   output logic [11:0]            source_file_addr,      // Move source
   output logic [11:0]            destination_file_addr, // Move dest
   output logic [19:0]            literal,    // Literal, zero extended
   output logic [20:0]            branch_target, // Absolute or offset
   output logic                   branch_rel, // Target is relative
   output logic [6:0]             source_index_offset,      // Src off
   output logic [6:0]             destination_index_offset, // Dst off
   output logic                   shadow_save,    // Save shadows
   output logic                   shadow_restore, // Restore shadows
   output logic [7:0]             shadow_acc,     // Shadow accumulator
   output logic [7:0]             shadow_status,  // Shadow status
   output logic [BANK_W-1:0]      shadow_bank,    // Shadow bank
   output logic [PTR_W-1:0]       table_pointer,  // Table pointer
   output logic [PTR_W-1:0]       table_addr,     // Access address
   output logic [7:0]             table_data_latch, // Table latch
   output logic [BANK_W-1:0]      bank_select_reg,  // Bank register
   output logic [7:0]             working_accumulator, // Accumulator
   output logic [4:0]             status_flags,   // Carry to negative
   output logic [7:0]             product_high_byte, // Product high
   output logic [7:0]             product_low_byte,  // Product low
   output logic [7:0]             program_counter_high_latch,  // PC hi
   output logic [7:0]             program_counter_upper_latch, // PC up
   output logic [20:0]            pc_load_value, // Assembled PC value
   output logic                   exec_nop,   // This cycle is a NOP
   output ofd_state_t             state       // Sequencer state
);
   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   logic       fld_a;                      // Access bank select bit
   logic       fld_d;                      // Destination bit
   logic       fld_s;                      // Fast bit
   logic [7:0] fld_f;                      // 8-bit file field
   logic       second_tag;                 // Top nibble all ones
   ofd_state_t state_d;                    // Next state
   logic [11:0] movff_src_q;               // Held first-word source

   assign fld_a = instr[8];
   assign fld_d = instr[9];
   assign fld_s = instr[8];
   assign fld_f = instr[7:0];
   assign second_tag = (instr[15:12] == `OFD_SECOND_TAG);

   // Bank/access addressing; the split keeps the low half of the access
   // area in RAM and the high half on the special register bank
   always_comb
   begin
      if (!fld_a)
         data_addr = (fld_f < `OFD_ACC_SPLIT) ? {4'h0, fld_f}
                                              : {`OFD_ACC_HI_BANK, fld_f};
      else
         data_addr = {bank_select_reg, fld_f};
   end

   // Destination routing only meaningful for byte operations
   assign dest_is_file = (fmt == OFD_FMT_BYTE) && fld_d;
   assign file_we    = result_wr && dest_is_file && !exec_nop;
   assign file_wdata = result;

   // Bit index and one-hot mask over the byte
   assign bit_index = instr[11:9];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_mask
         assign bit_mask[gi] = (fmt == OFD_FMT_BIT) &&
                               (bit_index == 3'(gi));
      end
   endgenerate

   // Pointer designator for pointer-loading literal form
   assign ptr_sel = instr[5:4];

   // Literal width follows the format in use
   always_comb
   begin
      unique case (fmt)
         OFD_FMT_LFSR:     literal = {8'h00, instr[11:0]};
         OFD_FMT_CTRL_ABS: literal = {instr[11:0], movff_src_q[7:0]};
         default:          literal = {12'h000, instr[7:0]};
      endcase
   end

   // Relative branches sign extend; absolute forms are word addresses
   always_comb
   begin
      branch_rel = (fmt == OFD_FMT_CTRL_REL);
      if (branch_rel)
         branch_target = instr[11] ? {{10{instr[10]}}, instr[10:0]}
                                   : {{13{instr[7]}}, instr[7:0]};
      else
         branch_target = {literal, 1'b0};
   end

   // Indexed offsets: source low seven bits, destination from the held first word
   assign source_index_offset      = instr[6:0];
   assign destination_index_offset = movff_src_q[6:0];

   // ----------------------------------------
   // Two-word sequencing
   // ----------------------------------------
   // First word fields are held so the second word completes them
   always_ff @(posedge clk)
   begin
      if (reset)
         movff_src_q <= 12'h000;
      else if (instr_valid && state == OFD_ST_FIRST && is_two_word)
         movff_src_q <= instr[11:0];
   end

   assign source_file_addr = movff_src_q;

   // Destination taken only from a genuine second word
   always_ff @(posedge clk)
   begin
      if (reset)
         destination_file_addr <= 12'h000;
      else if (instr_valid && state == OFD_ST_SECOND && second_tag &&
               fmt == OFD_FMT_MOVFF)
         destination_file_addr <= instr[11:0];
   end

   // Next state: pairs take two cycles, flow change adds a flush cycle
   always_comb
   begin
      state_d = state;
      unique case (state)
         OFD_ST_FIRST:
            if (instr_valid && is_two_word)
               state_d = OFD_ST_SECOND;
            else if (instr_valid && flow_change)
               state_d = OFD_ST_FLUSH;
         OFD_ST_SECOND:
            if (instr_valid)
               state_d = flow_change ? OFD_ST_FLUSH : OFD_ST_FIRST;
         OFD_ST_FLUSH:
            state_d = OFD_ST_FIRST;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state <= OFD_ST_FIRST;
      else
         state <= state_d;
   end

   // A lone second word or a flushed slot executes as a NOP
   assign exec_nop = (state == OFD_ST_FLUSH) ||
                     (state == OFD_ST_FIRST && second_tag && !is_two_word);

   // ----------------------------------------
   // Core registers
   // ----------------------------------------
   // Bank register
   always_ff @(posedge clk)
   begin
      if (reset)
         bank_select_reg <= BANK_W'(`OFD_BANK_RST);
      else if (shadow_restore)
         bank_select_reg <= shadow_bank;
      else if (bank_wr)
         bank_select_reg <= bank_val;
   end

   // Accumulator takes results when the destination bit is clear
   always_ff @(posedge clk)
   begin
      if (reset)
         working_accumulator <= `OFD_BYTE_RST;
      else if (shadow_restore)
         working_accumulator <= shadow_acc;
      else if (result_wr && !fld_d && fmt == OFD_FMT_BYTE && !exec_nop)
         working_accumulator <= result;
      else if (acc_wr)
         working_accumulator <= acc_wr_val;
   end

   // Five status flags, each with its own update enable
   always_ff @(posedge clk)
   begin
      if (reset)
         status_flags <= `OFD_STATUS_RST;
      else if (shadow_restore)
         status_flags <= shadow_status[4:0];
      else
         status_flags <= (status_flags & ~flags_we) |
                         (flags_in & flags_we);
   end

   // Fast call/return shadow control
   assign shadow_save    = call_ret && !is_return && fld_s;
   assign shadow_restore = call_ret && is_return && fld_s;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shadow_acc    <= `OFD_BYTE_RST;
         shadow_status <= `OFD_BYTE_RST;
         shadow_bank   <= BANK_W'(`OFD_BANK_RST);
      end
      else if (shadow_save)
      begin
         shadow_acc    <= working_accumulator;
         shadow_status <= status_in;
         shadow_bank   <= bank_select_reg;
      end
   end

   // Product bytes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         product_high_byte <= `OFD_BYTE_RST;
         product_low_byte  <= `OFD_BYTE_RST;
      end
      else if (product_wr)
      begin
         product_high_byte <= product[15:8];
         product_low_byte  <= product[7:0];
      end
   end

   // Counter latches; they only take effect when the PC is loaded
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         program_counter_high_latch  <= `OFD_BYTE_RST;
         program_counter_upper_latch <= `OFD_BYTE_RST;
      end
      else
      begin
         if (pc_high_latch_wr)
            program_counter_high_latch  <= latch_val;
         if (pc_upper_latch_wr)
            program_counter_upper_latch <= latch_val;
      end
   end

   always_comb
   begin
      pc_load_value = pc_load ? {program_counter_upper_latch[4:0],
                                 program_counter_high_latch,
                                 pc_low} : 21'h000000;
   end

   // ----------------------------------------
   // Table access
   // ----------------------------------------
   ofd_table_ptr #(
      .PTR_W (PTR_W)
   ) u_tbl (
      .clk              (clk),
      .reset            (reset),
      .access           (tbl_access),
      .mode             (ofd_tbl_mode_t'(instr[1:0])),
      .load             (tbl_load),
      .load_val         (tbl_load_val),
      .lat_wr           (tbl_lat_wr),
      .lat_val          (tbl_lat_val),
      .addr             (table_addr),
      .table_pointer    (table_pointer),
      .table_data_latch (table_data_latch)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // The access area never looks at the bank register
   access_bank_a: assert property (@(posedge clk) disable iff (reset)
      !fld_a |-> data_addr[7:0] == fld_f &&
                 data_addr[11:8] == (fld_f[7] ? `OFD_ACC_HI_BANK : 4'h0))
      else $error("access area address wrong");
   bank_sel_a: assert property (@(posedge clk) disable iff (reset)
      fld_a |-> data_addr == {bank_select_reg, fld_f})
      else $error("banked address wrong");
   dest_acc_a: assert property (@(posedge clk) disable iff (reset)
      result_wr && !fld_d && fmt == OFD_FMT_BYTE && !exec_nop &&
      !shadow_restore |=> working_accumulator == $past(result) &&
      !$past(file_we))
      else $error("result not routed to accumulator");
   bit_onehot_a: assert property (@(posedge clk) disable iff (reset)
      fmt == OFD_FMT_BIT |-> bit_mask == (8'h01 << bit_index))
      else $error("bit mask wrong");
   movff_pair_a: assert property (@(posedge clk) disable iff (reset)
      state == OFD_ST_FIRST && instr_valid && is_two_word
      |=> state == OFD_ST_SECOND &&
          source_file_addr == $past(instr[11:0]))
      else $error("two-word source not held");
   fast_save_a: assert property (@(posedge clk) disable iff (reset)
      shadow_save |=> shadow_acc == $past(working_accumulator))
      else $error("shadow save missed");
   product_a: assert property (@(posedge clk) disable iff (reset)
      product_wr |=> {product_high_byte, product_low_byte} ==
                     $past(product))
      else $error("product bytes wrong");
   // One NOP slot, then back to normal fetch
   sequence flush_slot_s;
      exec_nop ##1 state == OFD_ST_FIRST;
   endsequence
   flush_nop_a: assert property (@(posedge clk) disable iff (reset)
      state == OFD_ST_FIRST && instr_valid && !is_two_word && flow_change
      |=> flush_slot_s)
      else $error("flow change did not insert one NOP");
   lone_second_a: assert property (@(posedge clk) disable iff (reset)
      state == OFD_ST_FIRST && second_tag && !is_two_word
      |-> exec_nop && !file_we)
      else $error("lone second word not a NOP");
endmodule

// File: rtl/ofd_consts.svh
// Constants for the operand field decoder
// How it works
// - a=0 selects access RAM, ignores bank register
// - a=1 takes bank from bank select register
// - d=0 result to accumulator, d=1 to file
// - Bit index picks bit 0..7 of byte
// - File field: 8-bit address or 2-bit pointer
// - Two-word move source is 12-bit first word
// - Two-word move destination 12-bit second word
// - Fast bit 1 saves/restores shadows, 0 not
// - Table mode: none, post-inc, post-dec, pre-inc
// - 21-bit table pointer, 8-bit table latch
// - Literal is 8, 12 or 20 bits
// - Branch field relative signed or absolute direct
// - Indexed addressing: 7-bit source, destination offsets
// - Five flags: carry, half carry, zero, range, negative
// - Product held in high and low bytes
// - PC high and upper latches load upper bits
// - Second word has top nibble ones; alone NOP
// - One cycle, pairs two; one more when skip or PC change
`ifndef OFD_CONSTS_SVH
`define OFD_CONSTS_SVH
`define OFD_ACC_SPLIT    8'h80
`define OFD_ACC_HI_BANK  4'hf
`define OFD_SECOND_TAG   4'hf
`define OFD_TBL_PTR_RST  21'h000000
`define OFD_BYTE_RST     8'h00
`define OFD_BANK_RST     4'h0
`define OFD_STATUS_RST   5'h00
`endif

// File: rtl/ofd_pkg.sv
// Types for the operand field decoder
package ofd_pkg;
   // Instruction operand format chosen by the outside opcode decoder
   typedef enum logic [2:0] {
      OFD_FMT_BYTE,
      OFD_FMT_BIT,
      OFD_FMT_LIT,
      OFD_FMT_MOVFF,
      OFD_FMT_LFSR,
      OFD_FMT_CTRL_ABS,
      OFD_FMT_CTRL_REL,
      OFD_FMT_INDEXED
   } ofd_fmt_t;
   // Table pointer update mode
   typedef enum logic [1:0] {
      OFD_TBL_KEEP,
      OFD_TBL_POSTINC,
      OFD_TBL_POSTDEC,
      OFD_TBL_PREINC
   } ofd_tbl_mode_t;
   // Sequencer states
   typedef enum logic [1:0] {
      OFD_ST_FIRST,
      OFD_ST_SECOND,
      OFD_ST_FLUSH
   } ofd_state_t;
endpackage

// File: rtl/ofd_table_ptr.sv
// Table pointer and table data latch
`timescale 1ns/1ps
`include "ofd_consts.svh"
module ofd_table_ptr
   import ofd_pkg::*;
#(
   parameter int PTR_W = 21                 // Table pointer width
)(
   input  wire logic             clk,       // Core clock
   input  wire logic             reset,     // Sync reset, active high
   input  wire logic             access,    // Table access this cycle
   input  wire ofd_tbl_mode_t    mode,      // Pointer update mode
   input  wire logic             load,      // Load pointer from bus
   input  wire logic [PTR_W-1:0] load_val,  // Pointer load value
   input  wire logic             lat_wr,    // Write table latch
   input  wire logic [7:0]       lat_val,   // Table latch data in
   output logic      [PTR_W-1:0] addr,      // Address used by access
   output logic      [PTR_W-1:0] table_pointer,    // Pointer register
   output logic      [7:0]       table_data_latch  // Latch register
);
   // ----------------------------------------
   // Pointer update
   // ----------------------------------------
   logic [PTR_W-1:0] ptr_inc;               // Pointer plus one
   logic [PTR_W-1:0] ptr_dec;               // Pointer minus one
   assign ptr_inc = table_pointer + PTR_W'(1);
   assign ptr_dec = table_pointer - PTR_W'(1);
   // Pre-increment uses the bumped address for this access
   assign addr = (mode == OFD_TBL_PREINC) ? ptr_inc : table_pointer;

   // Pointer register; a load takes priority over an update
   always_ff @(posedge clk)
   begin
      if (reset)
         table_pointer <= PTR_W'(`OFD_TBL_PTR_RST);
      else if (load)
         table_pointer <= load_val;
      else if (access)
      begin
         unique case (mode)
            OFD_TBL_KEEP:    table_pointer <= table_pointer;
            OFD_TBL_POSTINC: table_pointer <= ptr_inc;
            OFD_TBL_POSTDEC: table_pointer <= ptr_dec;
            OFD_TBL_PREINC:  table_pointer <= ptr_inc;
         endcase
      end
   end

   // Byte latch through which table data moves
   always_ff @(posedge clk)
   begin
      if (reset)
         table_data_latch <= `OFD_BYTE_RST;
      else if (lat_wr)
         table_data_latch <= lat_val;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   tbl_postdec_a: assert property (@(posedge clk) disable iff (reset)
      access && !load && mode == OFD_TBL_POSTDEC
      |=> table_pointer == $past(table_pointer) - PTR_W'(1))
      else $error("table pointer post-decrement wrong");
   tbl_keep_a: assert property (@(posedge clk) disable iff (reset)
      access && !load && mode == OFD_TBL_KEEP |=> $stable(table_pointer))
      else $error("table pointer moved in keep mode");
endmodule

// File: sim/ofd_prog_mem.sv
// Program memory model supplying instruction words
`timescale 1ns/1ps
module ofd_prog_mem (
   input  wire logic [3:0]  pc,    // Word index from the bench
   output logic      [15:0] word   // Instruction word
);
   // ---------------------------------
   // Fixed program image
   // ---------------------------------
   // Spare bits are coded as zero so no test leans on them
   always_comb
   begin
      case (pc)
         4'h0:    word = 16'hc123; // Pair move, first word
         4'h1:    word = 16'hf456;
         4'h2:    word = 16'h2485; // Byte op, a=0 d=0 f=85
         4'h3:    word = 16'h2734; // Byte op, a=1 d=1 f=34
         4'h4:    word = 16'h8a10; // Bit op, bit 5 a=0 f=10
         4'h5:    word = 16'h0e7f; // Literal 7f
         4'h6:    word = 16'hf001;
         4'h7:    word = 16'hee25; // Pointer load, pointer 2
         4'h8:    word = 16'hd7fe; // Relative branch by -2
         4'h9:    word = 16'hed00; // Fast call
         4'ha:    word = 16'hec00; // Plain call
         4'hb:    word = 16'h0009; // Table post-increment
         4'hc:    word = 16'h000b; // Table pre-increment
         4'hd:    word = 16'h000a; // Table post-decrement
         4'he:    word = 16'heb45; // Indexed, offset 45
         default: word = 16'h0008;
      endcase
   end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module tb_top;
   import ofd_pkg::*;
   // ---------------------------------
   // Stimulus and observed signals
   // ---------------------------------
   logic        clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
   logic        is_two_word = 1'b0, flow_change = 1'b0, bank_wr = 1'b0;
   logic        acc_wr = 1'b0, result_wr = 1'b0, product_wr = 1'b0;
   logic        pc_high_latch_wr = 1'b0, pc_upper_latch_wr = 1'b0;
   logic        pc_load = 1'b0;
   logic        call_ret = 1'b0, is_return = 1'b0, tbl_access = 1'b0;
   logic        tbl_load = 1'b0, tbl_lat_wr = 1'b0;
   logic [15:0] instr, product = 16'h0000;
   logic [7:0]  acc_wr_val = 8'h00, result = 8'h00, latch_val = 8'h00;
   logic [7:0]  pc_low = 8'h00, status_in = 8'h00, tbl_lat_val = 8'h00;
   logic [4:0]  flags_in = 5'h00, flags_we = 5'h00;
   logic [3:0]  bank_val = 4'h0, pc = 4'h0;
   logic [20:0] tbl_load_val = 21'h000000;
   ofd_fmt_t    fmt = OFD_FMT_BYTE;
   logic [11:0] data_addr, source_file_addr, destination_file_addr;
   logic [20:0] branch_target, table_pointer, table_addr, pc_load_value;
   logic [7:0]  bit_mask, table_data_latch;
   logic [7:0]  product_high_byte, product_low_byte;
   logic [19:0] literal;
   logic [6:0]  source_index_offset;
   logic [4:0]  status_flags;
   logic [2:0]  bit_index;
   logic [1:0]  ptr_sel;
   logic        dest_is_file, branch_rel, shadow_save, exec_nop;
   logic        file_we, shadow_restore;
   logic [7:0]  file_wdata, shadow_acc, shadow_status, working_accumulator;
   logic [7:0]  program_counter_high_latch, program_counter_upper_latch;
   logic [6:0]  destination_index_offset;
   logic [3:0]  shadow_bank, bank_select_reg;
   ofd_state_t  state;
   int          err_total = 0, checks_done = 0;
   // Program memory feeds the word; every decoder port meets a bench net
   ofd_prog_mem u_mem (.pc(pc), .word(instr));
   ofd_decoder u_dut (.*);
   // Free-running 100 MHz core clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   // Present one word at a rising edge; caller adds strobes after
   task automatic issue(input logic [3:0] a, input ofd_fmt_t f,
                        input logic two);
      @(posedge clk);
      pc <= a;
      fmt <= f;
      is_two_word <= two;
      instr_valid <= 1'b1;
   endtask
   // Compare one value, counting every look
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask
   // Single closing point for normal end and for the watchdog
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog: a stuck run counts as a mismatch
   initial
   begin
      #200000;
      err_total = err_total + 1;
      results();
   end
   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      issue(4'h0, OFD_FMT_MOVFF, 1'b1);
      issue(4'h1, OFD_FMT_MOVFF, 1'b0);
      #1 chk({source_file_addr, destination_index_offset}, 19'h091a3);
      issue(4'h2, OFD_FMT_BYTE, 1'b0);
      bank_wr <= 1'b1;
      bank_val <= 4'h5;
      {result_wr, result} <= 9'h13c;
      #1 chk(destination_file_addr, 12'h456);
      chk({data_addr, 3'h0, dest_is_file}, 16'hf850);
      issue(4'h3, OFD_FMT_BYTE, 1'b0);
      bank_wr <= 1'b0;
      result <= 8'h5a;
      #1 chk({data_addr, 3'h0, dest_is_file}, 16'h5341);
      chk({working_accumulator, file_we, file_wdata}, 17'h0795a);
      issue(4'h4, OFD_FMT_BIT, 1'b0);
      result_wr <= 1'b0;
      #1 chk({data_addr, bit_mask, bit_index}, 23'h008105);
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      #1 chk({exec_nop, literal}, 21'h0007f);
      issue(4'h6, OFD_FMT_MOVFF, 1'b0);
      issue(4'h7, OFD_FMT_LFSR, 1'b0);
      #1 chk({destination_file_addr, ptr_sel}, 14'h115a);
      issue(4'h8, OFD_FMT_CTRL_REL, 1'b0);
      #1 chk({branch_rel, branch_target}, 22'h3ffffe);
      issue(4'he, OFD_FMT_INDEXED, 1'b0);
      #1 chk(source_index_offset, 7'h45);
      issue(4'h9, OFD_FMT_CTRL_ABS, 1'b0);
      {call_ret, status_in} <= 9'h10b;
      #1 chk(shadow_save, 1'b1);
      issue(4'ha, OFD_FMT_CTRL_ABS, 1'b0);
      tbl_load <= 1'b1;
      tbl_load_val <= 21'h1ffffe;
      tbl_lat_wr <= 1'b1;
      tbl_lat_val <= 8'ha5;
      #1 chk(shadow_save, 1'b0);
      chk({shadow_acc, shadow_status, shadow_bank}, 20'h3c0b5);
      issue(4'hb, OFD_FMT_CTRL_ABS, 1'b0);
      call_ret <= 1'b0;
      {tbl_load, tbl_lat_wr, tbl_access} <= 3'b001;
      #1 chk({table_data_latch, table_addr}, 29'h14bffffe);
      issue(4'hc, OFD_FMT_CTRL_ABS, 1'b0);
      #1 chk({table_pointer, table_addr}, 42'h3ffffe00000);
      issue(4'hd, OFD_FMT_CTRL_ABS, 1'b0);
      #1 chk({table_pointer, table_addr}, 42'h0);
      issue(4'hf, OFD_FMT_CTRL_ABS, 1'b0);
      #1 chk(table_addr, 21'h1fffff);
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      tbl_access <= 1'b0;
      {flags_in, flags_we} <= 10'h2bf;
      {product_wr, product} <= 17'h1abcd;
      {pc_high_latch_wr, latch_val} <= 9'h112;
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      {flags_in, flags_we, product_wr, pc_high_latch_wr} <= 12'h004;
      {pc_upper_latch_wr, latch_val} <= 9'h11f;
      #1 chk(table_pointer, 21'h1fffff);
      chk({status_flags, product_high_byte, product_low_byte},
          21'h15abcd);
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      {flags_we, pc_upper_latch_wr, pc_load, pc_low} <= 15'h0134;
      flow_change <= 1'b1;
      #1 chk({status_flags, pc_load_value}, 26'h29f1234);
      chk({program_counter_high_latch, program_counter_upper_latch}, 16'h121f);
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      {flow_change, pc_load} <= 2'b00;
      #1 chk({exec_nop, state}, {1'b1, OFD_ST_FLUSH});
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      {acc_wr, acc_wr_val, bank_wr, bank_val} <= 14'h2ef9;
      #1 chk(state, OFD_ST_FIRST);
      // Fast return must bring back the saved accumulator, flags, bank
      issue(4'h9, OFD_FMT_CTRL_ABS, 1'b0);
      {acc_wr, bank_wr, call_ret, is_return} <= 4'h3;
      #1 chk({working_accumulator, bank_select_reg}, 12'h779);
      chk(shadow_restore, 1'b1);
      issue(4'h5, OFD_FMT_LIT, 1'b0);
      {call_ret, is_return} <= 2'b00;
      #1 chk({working_accumulator, bank_select_reg}, 12'h3c5);
      chk(status_flags, 5'h0b);
      results();
   end
endmodule
